/* File: inc/pao_pkg.sv */
// package: constants and carrier types for the converter output port
`default_nettype none
package pao_pkg;
  localparam int PAO_W = 10;
  localparam logic [9:0] PAO_CODE_MIN = 10'h000;
  localparam logic [9:0] PAO_CODE_MAX = 10'h3ff;
  localparam int PAO_LATENCY = 2;
  localparam int PAO_CLK_MHZ = 10;
  localparam int PAO_WAKE_NS = 700;
  localparam int PAO_WAKE_CYC = (PAO_WAKE_NS * PAO_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] PAO_WAKE_CYC4 = 4'(PAO_WAKE_CYC);
  // one sample moving down the pipeline
  typedef struct packed {
    logic vld;
    logic [PAO_W-1:0] code;
  } pao_smp_t;
endpackage : pao_pkg
`default_nettype wire

/* File: hw/pao_port.sv */
// design: digital output port of a 10-bit pipelined sampling converter
`default_nettype none
// Function
// - take one sample every falling clock edge while standby request is low
// - code appears on the bus two cycles after its sampling edge
// - a new output word every cycle while converting
// - output word changes only after a falling edge; old word held until then
// - conversion runs only while standby request is low
// - drivers on when drive enable low and standby low
// - all data lines high impedance when drive enable or standby is high
// - below-range input gives all zeros, above-range gives all ones
// - each sample quantised to ten bits
// - codes are straight binary 0 to 1023
// - words before the wake-up interval after standby release are not accurate
module pao_port
  import pao_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic signed [11:0] analog_in,
  input wire logic in_below,
  input wire logic in_above,
  input wire logic drive_en_n,
  input wire logic standby_request,
  output logic [PAO_W-1:0] data_out,
  output logic [PAO_W-1:0] data_oe_n,
  output logic data_valid,
  output logic data_accurate
);
  pao_smp_t stage0_r;
  pao_smp_t stage1_r;
  logic [PAO_W-1:0] data_r;
  logic [PAO_W-1:0] oe_n_r;
  logic valid_r;
  logic accurate_r;
  logic [3:0] wake_cnt_r;
  logic [PAO_W-1:0] quant_nxt;
  logic [3:0] low_run_r;
  logic [PAO_W-1:0] rise_word_r;

  // quantiser with saturation; the analog model is given as a signed sample
  always_comb begin
    if (in_below || analog_in < 12'sd0) begin
      quant_nxt = PAO_CODE_MIN;
    end else if (in_above || analog_in > 12'sd1023) begin
      quant_nxt = PAO_CODE_MAX;
    end else begin
      quant_nxt = analog_in[PAO_W-1:0];
    end
  end

  // sampling and pipeline stages, all on the falling edge
  always_ff @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage0_r <= '0;
      stage1_r <= '0;
    end else begin
      stage0_r.vld <= !standby_request;
      stage0_r.code <= standby_request ? stage0_r.code : quant_nxt;
      stage1_r <= stage0_r;
    end
  end

  // output register: second stage presents the word; stall holds it
  always_ff @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_r <= '0;
      valid_r <= 1'b0;
    end else begin
      if (stage1_r.vld && !standby_request) begin
        data_r <= stage1_r.code;
      end
      valid_r <= stage1_r.vld && !standby_request;
    end
  end

  // drive enables; low enable means the pin is driven
  always_ff @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_n_r <= '1;
    end else begin
      oe_n_r <= {PAO_W{drive_en_n || standby_request}};
    end
  end

  // wake-up timer after standby release; words before it are flagged
  // the timer reloads on every clock edge in standby, so a short standby restarts the wait
  always_ff @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_cnt_r <= PAO_WAKE_CYC4;
      accurate_r <= 1'b0;
    end else if (standby_request) begin
      wake_cnt_r <= PAO_WAKE_CYC4;
      accurate_r <= 1'b0;
    end else if (wake_cnt_r != 4'h0) begin
      wake_cnt_r <= wake_cnt_r - 4'h1;
      accurate_r <= 1'b0;
    end else begin
      accurate_r <= 1'b1;
    end
  end

  assign data_out = data_r;
  assign data_oe_n = oe_n_r;
  assign data_valid = valid_r;
  assign data_accurate = accurate_r;

  // assertion helper: falling edges seen since standby was last high
  // kept apart from the wake timer on purpose, so a slip in that timer
  // shows up as a disagreement between the two counts
  always_ff @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_run_r <= 4'h0;
    end else if (standby_request) begin
      low_run_r <= 4'h0;
    end else if (low_run_r != 4'hf) begin
      low_run_r <= low_run_r + 4'h1; // saturates, the checks need only the first few
    end
  end

  // assertion helper: the word as a rising-edge capture stage would see it
  // the far side latches mid-cycle, so this is the copy that must not move
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rise_word_r <= '0;
    end else begin
      rise_word_r <= data_out;
    end
  end

  // assertions, sampled on the conversion edge
  sequence standby_pair_s;
    standby_request [*2];
  endsequence

  sequence conv_run_s;
    !standby_request [*3];
  endsequence

  // the sample taken at the first edge of a run stands on the bus after the third
  property lat_p;
    @(negedge clk) disable iff (!arst_n)
      (!standby_request && !in_below && !in_above && analog_in >= 12'sd0
       && analog_in <= 12'sd1023) ##0 conv_run_s
      |=> data_out == $past(analog_in[PAO_W-1:0], 3);
  endproperty
  pipe_latency_a: assert property (lat_p) else $error("latency wrong");

  stream_rate_a: assert property (@(negedge clk) disable iff (!arst_n)
    conv_run_s |=> data_valid)
    else $error("no word every cycle");

  // saturation travels the same pipeline as a plain code
  sat_low_a: assert property (@(negedge clk) disable iff (!arst_n)
    (in_below && !in_above) ##0 conv_run_s |=> data_out == PAO_CODE_MIN)
    else $error("low saturation wrong");

  // over-range input clamps to the top code, never wraps
  sat_high_a: assert property (@(negedge clk) disable iff (!arst_n)
    (in_above && !in_below) ##0 conv_run_s |=> data_out == PAO_CODE_MAX)
    else $error("high saturation wrong");

  // both flags at once: the lower one wins
  sat_both_a: assert property (@(negedge clk) disable iff (!arst_n)
    (in_below && in_above) ##0 conv_run_s |=> data_out == PAO_CODE_MIN)
    else $error("double saturation wrong");

  drive_off_a: assert property (@(negedge clk) disable iff (!arst_n)
    (drive_en_n || standby_request) |=> data_oe_n == '1)
    else $error("bus not released");

  // enable and standby both low: every line driven from the next edge
  drive_on_a: assert property (@(negedge clk) disable iff (!arst_n)
    (!drive_en_n && !standby_request) |=> data_oe_n == '0)
    else $error("bus not driven");

  // a long standby keeps the lines released the whole time
  standby_float_a: assert property (@(negedge clk) disable iff (!arst_n)
    standby_pair_s |-> data_oe_n == '1)
    else $error("bus driven in standby");

  standby_hold_a: assert property (@(negedge clk) disable iff (!arst_n)
    standby_request |=> (!data_valid && $stable(data_out)))
    else $error("conversion during standby");

  standby_freeze_a: assert property (@(negedge clk) disable iff (!arst_n)
    standby_request |=> (!stage0_r.vld && $stable(stage0_r.code)))
    else $error("sample taken in standby");

  sample_take_a: assert property (@(negedge clk) disable iff (!arst_n)
    !standby_request |=> stage0_r.vld)
    else $error("sample missed");

  // a fresh word always traces back to a converting edge
  valid_run_a: assert property (@(negedge clk) disable iff (!arst_n)
    data_valid |-> !$past(standby_request))
    else $error("word without conversion");

  // the rising edge sits mid-cycle, where the far side latches; nothing may move there
  word_stable_a: assert property (@(negedge clk) disable iff (!arst_n)
    data_out == rise_word_r) else $error("word moved between edges");

  wake_gate_a: assert property (@(negedge clk) disable iff (!arst_n)
    $fell(standby_request) |-> !data_accurate [*7])
    else $error("accurate too early");

  // the long wait is counted in helper logic rather than by a long repetition
  wake_end_a: assert property (@(negedge clk) disable iff (!arst_n)
    (!standby_request && low_run_r > PAO_WAKE_CYC4) |-> data_accurate)
    else $error("accurate too late");

  wake_count_a: assert property (@(negedge clk) disable iff (!arst_n)
    (low_run_r <= PAO_WAKE_CYC4) |-> !data_accurate)
    else $error("accurate before wake-up");

  accurate_drop_a: assert property (@(negedge clk) disable iff (!arst_n)
    standby_request |=> !data_accurate)
    else $error("accurate kept in standby");

  // reset values; not disabled, since reset itself is what is checked here
  reset_vals_a: assert property (@(negedge clk)
    !arst_n |=> (data_oe_n == '1 && !data_valid && !data_accurate && data_out == '0))
    else $error("reset values wrong");
endmodule : pao_port
`default_nettype wire

/* File: tb/pao_capture.sv */
// partner model: capture logic latching the converter output word
`default_nettype none
module pao_capture
  import pao_pkg::*;
(
  input wire logic clk,
  input wire logic [PAO_W-1:0] data_out,
  input wire logic [PAO_W-1:0] data_oe_n,
  input wire logic data_valid,
  input wire logic data_accurate,
  output logic [PAO_W-1:0] word_r
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [PAO_W-1:0] last_r;
  logic [PAO_W-1:0] bus;
  // a released line shows the inverse of its last level, never a stale copy
  assign bus = (data_out & ~data_oe_n) | (~last_r & data_oe_n);
  // latch on the rising edge, half a period after the output delay has passed
  always_ff @(posedge clk) begin
    last_r <= bus;
    // words from before the wake-up interval are dropped, as are stale ones
    if (data_valid && data_accurate && data_oe_n == 10'h000) begin
      word_r <= bus;
    end
  end
endmodule : pao_capture
`default_nettype wire

/* File: tb/pipelined_adc_output_port_test.sv */
// testbench: stream, saturation, standby and drive enable of the output port
`default_nettype none
module pipelined_adc_output_port_test
  import pao_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [11:0] a; logic lo; logic hi; logic [9:0] c;} pao_row_t;
  // plain codes, both ends of the span, and saturation by value and by flag
  localparam pao_row_t ROWS [8] = '{'{12'h000, 1'b0, 1'b0, 10'h000},
    '{12'h3ff, 1'b0, 1'b0, 10'h3ff}, '{12'hffb, 1'b0, 1'b0, 10'h000},
    '{12'h7d0, 1'b0, 1'b0, 10'h3ff}, '{12'h1f4, 1'b1, 1'b0, 10'h000},
    '{12'h003, 1'b0, 1'b1, 10'h3ff}, '{12'h003, 1'b1, 1'b1, 10'h000},
    '{12'h200, 1'b0, 1'b0, 10'h200}};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] ain = 12'h000;
  logic lo = 1'b0;
  logic hi = 1'b0;
  logic drive_en_n = 1'b1;
  logic standby_request = 1'b0;
  logic [9:0] dout;
  logic [9:0] oe_n;
  logic [9:0] word;
  logic dvld;
  logic dacc;
  int error_cnt = 0;
  int total_checks = 0;
  int n;
  always #50 clk = ~clk;
  pao_port DUT (.clk(clk), .arst_n(arst_n), .analog_in(ain), .in_below(lo), .in_above(hi),
    .drive_en_n(drive_en_n), .standby_request(standby_request), .data_out(dout),
    .data_oe_n(oe_n), .data_valid(dvld), .data_accurate(dacc));
  pao_capture cap (.clk(clk), .data_out(dout), .data_oe_n(oe_n), .data_valid(dvld),
    .data_accurate(dacc), .word_r(word));
  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // inputs move by non-blocking assignment at the falling edge, seen one edge later
  initial begin
    repeat (5) @(negedge clk);
    chk("oe_n", 10'h3ff, oe_n);
    arst_n <= 1'b1;
    drive_en_n <= 1'b0;
    repeat (12) @(negedge clk);
    for (int i = 0; i < 11; i++) begin
      @(negedge clk);
      if (i < 8) begin
        ain <= ROWS[i].a;
        lo <= ROWS[i].lo;
        hi <= ROWS[i].hi;
      end
      @(posedge clk);
      #1;
      if (i >= 3) begin
        chk("data", ROWS[i-3].c, dout);
        chk("capture", ROWS[i-3].c, word);
        chk("valid", 10'h001, {9'h000, dvld});
        chk("oe_n", 10'h000, oe_n);
      end
    end
    // a new code is taken one edge before standby; it must not reach the bus while standby holds
    @(negedge clk);
    ain <= 12'h155;
    lo <= 1'b0;
    hi <= 1'b0;
    @(negedge clk);
    standby_request <= 1'b1;
    repeat (2) @(negedge clk);
    #1;
    chk("oe_n", 10'h3ff, oe_n);
    chk("valid", 10'h000, {9'h000, dvld});
    chk("hold", 10'h200, dout);
    @(negedge clk);
    standby_request <= 1'b0;
    n = 0;
    while (dacc !== 1'b1 && n < 20) begin
      @(negedge clk);
      #1;
      n++;
    end
    chk("wake", 10'(PAO_WAKE_CYC + 1), 10'(n));
    if (n == 20) end_of_test();
    chk("data", 10'h155, dout);
    @(negedge clk);
    drive_en_n <= 1'b1;
    @(negedge clk);
    #1;
    chk("oe_n", 10'h3ff, oe_n);
    // a reset in mid-stream clears the word and its valid and accurate flags at once
    @(negedge clk);
    arst_n <= 1'b0;
    #1;
    chk("reset data", 10'h000, dout);
    chk("reset valid", 10'h000, {9'h000, dvld});
    chk("reset accurate", 10'h000, {9'h000, dacc});
    end_of_test();
  end
endmodule : pipelined_adc_output_port_test
`default_nettype wire
